//--- verification/pct_pins.sv
`timescale 1ns/10ps
`default_nettype none
module pct_pins (
	// Clock
	input  wire logic       clk_i,
	// Levels asked for by the bench
	input  wire logic [1:0] level_i,
	// Pins of the block
	output logic      [1:0] capture_inputs_o = 2'h0,
	input  wire logic [1:0] match_outputs_i,
	output logic      [1:0] match_seen_o = 2'h0
);
	// Source is synchronous to the block clock, so it moves just after an edge
	always @(posedge clk_i) begin
		capture_inputs_o <= level_i;
		match_seen_o <= match_outputs_i;
	end
endmodule // pct_pins
`default_nettype wire

//--- verification/pct_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pct_timer_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rstn_i,
	// Register bus
	input wire logic [6:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o
);
	// Every bus relation is sampled on the one clock
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Handshake: one wait state, answer lasts a single cycle
	a_wait_one: assert property ($rose(avs_read_i | avs_write_i) |=> !avs_waitrequest_o)
		else $error("bus answer late");
	a_wait_idle: assert property (!(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
		else $error("answer without request");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer held too long");
	a_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_waitrequest_o))
		else $error("answer without wait state");
	// Read data moves only when a read is answered
	a_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i) && !avs_waitrequest_o)
		else $error("read data moved");
	// Unused bits and unmapped places read zero
	a_flag_bits: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 7'h00
		|-> avs_readdata_o[31:7] == 25'h0 && !avs_readdata_o[5])
		else $error("flag register spare bits set");
	a_count_width: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i inside {7'h08, 7'h0c, 7'h10} |-> avs_readdata_o[31:16] == 16'h0)
		else $error("count wider than 16 bits");
	a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 7'h30
		|-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
endmodule // pct_timer_chk
bind pct_timer pct_timer_chk u_pct_timer_chk (.clk_i, .rstn_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_readdata_o, .avs_waitrequest_o);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [6:0]  adr = 7'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic        wt;
	logic [1:0]  lvl = 2'h0;
	logic [1:0]  cap;
	logic [1:0]  mo;
	logic [1:0]  seen;
	logic [31:0] v;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////
	// Clock, block and pin model
	initial forever #4 clk_i = ~clk_i;
	pct_timer u_pct_timer (.clk_i, .rstn_i, .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wt), .capture_inputs_i(cap),
		.match_outputs_o(mo));
	pct_pins u_pct_pins (.clk_i, .level_i(lvl), .capture_inputs_o(cap),
		.match_outputs_i(mo), .match_seen_o(seen));
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is seen low; no answer time is assumed
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk_i); while (wt !== 1'b0);
		v = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rchk(input logic [6:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(v, e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [6:0] a[15] = '{7'h00, 7'h04, 7'h08, 7'h0c, 7'h10, 7'h14, 7'h18, 7'h1c,
			7'h20, 7'h24, 7'h28, 7'h2c, 7'h3c, 7'h70, 7'h74};
		foreach (a[i]) rchk(a[i], 32'h0);
		bus(1'b1, 7'h30, 32'hffff);
		rchk(7'h30, 32'h0);
	endtask
	task automatic t_regs();
		bus(1'b1, 7'h10, 32'h5);
		rchk(7'h10, 32'h5);
		bus(1'b1, 7'h08, 32'h7);
		bus(1'b1, 7'h04, 32'h2);
		rchk(7'h08, 32'h0);
		rchk(7'h10, 32'h0);
		bus(1'b1, 7'h04, 32'h0);
	endtask
	// Six rising edges of capture input 0 through a divide-by-two
	task automatic t_count();
		bus(1'b1, 7'h70, 32'h1);
		bus(1'b1, 7'h0c, 32'h1);
		bus(1'b1, 7'h04, 32'h1);
		repeat (6) begin
			@(posedge clk_i);
			lvl <= 2'h1;
			repeat (2) @(posedge clk_i);
			lvl <= 2'h0;
			@(posedge clk_i);
		end
		bus(1'b1, 7'h04, 32'h0);
		rchk(7'h08, 32'h3);
		rchk(7'h10, 32'h0);
		bus(1'b1, 7'h70, 32'h0);
		bus(1'b1, 7'h0c, 32'h0);
	endtask
	task automatic t_match();
		bus(1'b1, 7'h18, 32'h3);
		bus(1'b1, 7'h14, 32'h3);
		bus(1'b1, 7'h3c, 32'h8);
		bus(1'b1, 7'h04, 32'h1);
		repeat (20) @(posedge clk_i);
		bus(1'b1, 7'h04, 32'h0);
		bus(1'b0, 7'h08, 32'h0);
		chk({16'h0, v[15:2]}, 32'h0);
		chk({30'h0, seen}, 32'h1);
		bus(1'b1, 7'h00, 32'h0);
		rchk(7'h00, 32'h1);
		bus(1'b1, 7'h00, 32'h1);
		rchk(7'h00, 32'h0);
		// Stop on match must leave the count on the compare value
		bus(1'b1, 7'h14, 32'h4);
		bus(1'b1, 7'h08, 32'h0);
		bus(1'b1, 7'h3c, 32'hd);
		bus(1'b1, 7'h04, 32'h1);
		repeat (10) @(posedge clk_i);
		rchk(7'h04, 32'h0);
		rchk(7'h08, 32'h3);
		chk({30'h0, seen}, 32'h0);
		rchk(7'h3c, 32'hc);
		bus(1'b1, 7'h14, 32'h0);
	endtask
	// Capture 0 on rise without flag, capture 1 on fall with flag, clear on capture 0
	task automatic t_capture();
		lvl <= 2'h2;
		bus(1'b1, 7'h08, 32'h1234);
		bus(1'b1, 7'h10, 32'h5);
		bus(1'b1, 7'h00, 32'h7f);
		bus(1'b1, 7'h28, 32'h31);
		bus(1'b1, 7'h70, 32'h8);
		lvl <= 2'h1;
		repeat (3) @(posedge clk_i);
		rchk(7'h2c, 32'h1234);
		rchk(7'h34, 32'h1234);
		rchk(7'h00, 32'h40);
		rchk(7'h08, 32'h0);
		rchk(7'h10, 32'h0);
	endtask
	// Count from just below the top wraps through zero onto a stop match
	task automatic t_wrap();
		bus(1'b1, 7'h20, 32'h2);
		bus(1'b1, 7'h14, 32'h100);
		bus(1'b1, 7'h08, 32'hfffe);
		bus(1'b1, 7'h04, 32'h1);
		repeat (10) @(posedge clk_i);
		rchk(7'h08, 32'h2);
		rchk(7'h04, 32'h0);
		bus(1'b1, 7'h14, 32'h0);
	endtask
	// Pin 1 as PWM against a stopped count, then with a period on pinless channel 3
	task automatic t_pwm();
		int hi = 0;
		bus(1'b1, 7'h74, 32'h2);
		bus(1'b1, 7'h1c, 32'h0);
		repeat (2) @(posedge clk_i);
		chk({31'h0, mo[1]}, 32'h1);
		bus(1'b1, 7'h1c, 32'h5);
		repeat (2) @(posedge clk_i);
		chk({31'h0, mo[1]}, 32'h0);
		bus(1'b1, 7'h24, 32'h9);
		bus(1'b1, 7'h14, 32'h400);
		bus(1'b1, 7'h04, 32'h1);
		repeat (4) @(posedge clk_i);
		// Two whole periods of ten: five cycles high in each
		repeat (20) begin
			@(negedge clk_i);
			hi += mo[1];
		end
		bus(1'b1, 7'h04, 32'h0);
		chk(hi, 32'ha);
	endtask
	////////////////////////////////////////////////////////////////
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_regs();
		t_count();
		t_match();
		t_capture();
		t_wrap();
		t_pwm();
		final_report();
	end
endmodule // tb_top
`default_nettype wire

//--- verilog/pct_pkg.sv
package pct_pkg;
	// Count source: timer or counting edges of a capture input
	typedef enum logic [1:0] {
		PCT_TIMER = 2'b00,
		PCT_RISE  = 2'b01,
		PCT_FALL  = 2'b10,
		PCT_BOTH  = 2'b11
	} pct_mode_t;
	// Action of a match on its external output
	typedef enum logic [1:0] {
		PCT_EM_NONE   = 2'b00,
		PCT_EM_LOW    = 2'b01,
		PCT_EM_HIGH   = 2'b10,
		PCT_EM_TOGGLE = 2'b11
	} pct_em_t;
	// Whole block state
	typedef struct packed {
		logic [6:0]        iflags;
		logic [1:0]        runc;
		logic [15:0]       tcount;
		logic [15:0]       dlimit;
		logic [15:0]       dcount;
		logic [11:0]       mact;
		logic [3:0][15:0]  cmp;
		logic [5:0]        cedge;
		logic [1:0][15:0]  capv;
		logic [5:0]        ext;
		logic [5:0]        csrc;
		logic [1:0]        pwm;
		logic [1:0]        cap_prev;
		logic [3:0]        eq_prev;
		logic [1:0]        mout;
		logic              busy;
		logic [31:0]       rdata;
	} pct_state_t;
endpackage

//--- verilog/pct_regs.svh
`ifndef PCT_REGS_SVH
`define PCT_REGS_SVH
// Register byte offsets
`define PCT_OFS_FLAGS   7'h00
`define PCT_OFS_RUN     7'h04
`define PCT_OFS_COUNT   7'h08
`define PCT_OFS_LIMIT   7'h0c
`define PCT_OFS_DIV     7'h10
`define PCT_OFS_MACT    7'h14
`define PCT_OFS_CMP0    7'h18
`define PCT_OFS_CMP1    7'h1c
`define PCT_OFS_CMP2    7'h20
`define PCT_OFS_CMP3    7'h24
`define PCT_OFS_CEDGE   7'h28
`define PCT_OFS_CAP0    7'h2c
`define PCT_OFS_CAP1    7'h34
`define PCT_OFS_EXT     7'h3c
`define PCT_OFS_CSRC    7'h70
`define PCT_OFS_PWM     7'h74
// Field positions
`define PCT_FLAG_CAP0   4
`define PCT_FLAG_CAP1   6
`define PCT_FLAG_SPARE  5
`define PCT_RUN_EN      0
`define PCT_RUN_RST     1
`define PCT_MACT_IRQ    0
`define PCT_MACT_RST    1
`define PCT_MACT_STOP   2
`define PCT_MACT_W      3
`define PCT_CEDGE_RISE  0
`define PCT_CEDGE_FALL  1
`define PCT_CEDGE_IRQ   2
`define PCT_CEDGE_W     3
`define PCT_EXT_ACT     2
`define PCT_EXT_ACT_W   2
`define PCT_CSRC_SEL    2
`define PCT_CSRC_CLREN  3
`define PCT_CSRC_CLRFAL 4
`define PCT_CSRC_CLRCH  5
// Reset values
`define PCT_RST_ZERO    '0
`define PCT_RST_BUSY    1'b1
`endif

//--- verilog/pct_timer.sv
// What this block does
// - The 16-bit count advances once each time the tick divider completes, every limit+1 steps of the count source.
// - When the divider count equals its limit, the next count step bumps the count and zeroes the divider.
// - Software can read and overwrite the divider count over the bus.
// - Pending match and capture events show in a flag register, cleared by writing ones.
// - A run-control register stops the count or holds it at its reset value.
// - Each of four compare values can, on equality, reset the count, stop counting and flag.
// - Capture register 0 or 1 loads the count on a chosen event of capture input 0 or 1.
// - Per capture input software picks the loading edges and whether a capture flags.
// - A chosen capture event can clear both count and divider for pulse-width measurement.
// - On a match the external output goes low, high, toggles or stays as configured.
// - Timer mode counts clock cycles; counter mode counts chosen edges of a chosen input.
// - A capture input can replace the clock-derived tick as the count source.
// - A per-pin enable turns the external output into a single-edge PWM waveform.
// - Every control, count, compare and first capture register reads zero after reset.
// - Four match flags and two capture flags are high while pending and low otherwise.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pct_regs.svh"

module pct_timer (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// Avalon-MM slave
	input  wire logic [6:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Pins
	input  wire logic [1:0]  capture_inputs_i,
	output logic      [1:0]  match_outputs_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge write data into an old word under byte enables
	function automatic logic [31:0] pct_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Edge of a sampled input, rising and/or falling as enabled
	function automatic logic pct_edge(
		input logic prev,
		input logic cur,
		input logic rise,
		input logic fall
	);
		return (rise && !prev && cur) || (fall && prev && !cur);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	pct_pkg::pct_state_t st;
	pct_pkg::pct_state_t nx;

	logic              req;
	logic              take_wr;
	logic [31:0]       rmux;
	logic [31:0]       wdm;
	logic [31:0]       wdz;
	logic              step;
	logic              wrap;
	logic              rst_hit;
	logic              stop_hit;
	logic              cnt_edge;
	logic              clr_cap;
	logic              src;
	logic              clr_ch;
	logic [3:0]        eq;
	logic [3:0]        mev;
	logic [1:0]        cev;
	logic [6:0]        setv;
	logic [6:0]        clrv;
	pct_pkg::pct_mode_t mode;
	pct_pkg::pct_em_t   act;

	////////////////////////////////////////////////////////////////////////////////
	// Read mux, unmapped words read as zero
	always_comb begin
		rmux = '0;
		case (avs_address_i)
			`PCT_OFS_FLAGS: rmux[6:0]  = st.iflags;
			`PCT_OFS_RUN:   rmux[1:0]  = st.runc;
			`PCT_OFS_COUNT: rmux[15:0] = st.tcount;
			`PCT_OFS_LIMIT: rmux[15:0] = st.dlimit;
			`PCT_OFS_DIV:   rmux[15:0] = st.dcount;
			`PCT_OFS_MACT:  rmux[11:0] = st.mact;
			`PCT_OFS_CMP0:  rmux[15:0] = st.cmp[0];
			`PCT_OFS_CMP1:  rmux[15:0] = st.cmp[1];
			`PCT_OFS_CMP2:  rmux[15:0] = st.cmp[2];
			`PCT_OFS_CMP3:  rmux[15:0] = st.cmp[3];
			`PCT_OFS_CEDGE: rmux[5:0]  = st.cedge;
			`PCT_OFS_CAP0:  rmux[15:0] = st.capv[0];
			`PCT_OFS_CAP1:  rmux[15:0] = st.capv[1];
			`PCT_OFS_EXT:   rmux[5:0]  = st.ext;
			`PCT_OFS_CSRC:  rmux[5:0]  = st.csrc;
			`PCT_OFS_PWM:   rmux[1:0]  = st.pwm;
			default:        rmux = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		nx = st;
		setv = '0;
		clrv = '0;
		act = pct_pkg::PCT_EM_NONE;

		// Bus handshake: one wait cycle, then the request is taken
		req = avs_read_i || avs_write_i;
		take_wr = avs_write_i && !st.busy;
		nx.busy = !(req && st.busy);
		// Only a read moves readdata, so a write leaves the last read word standing
		if (avs_read_i && st.busy) begin
			nx.rdata = rmux; // Sampled a cycle early so readdata comes from a flop
		end
		wdm = pct_merge(rmux, avs_writedata_i, avs_byteenable_i);
		wdz = pct_merge(32'h0, avs_writedata_i, avs_byteenable_i); // Unwritten lanes clear nothing

		// Count source: clock tick or edges of a capture input
		mode = pct_pkg::pct_mode_t'(st.csrc[1:0]);
		src = st.csrc[`PCT_CSRC_SEL];
		cnt_edge = pct_edge(st.cap_prev[src], capture_inputs_i[src], mode[0], mode[1]);
		step = st.runc[`PCT_RUN_EN]
			&& (mode == pct_pkg::PCT_TIMER || cnt_edge);

		// Compare equality and first-cycle match events
		for (int i = 0; i < 4; i++) begin
			eq[i] = st.tcount == st.cmp[i];
		end
		mev = eq & ~st.eq_prev;
		nx.eq_prev = eq;
		rst_hit = 1'b0;
		stop_hit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (eq[i] && st.mact[i*`PCT_MACT_W + `PCT_MACT_RST]) begin
				rst_hit = 1'b1;
			end
			if (mev[i] && st.mact[i*`PCT_MACT_W + `PCT_MACT_STOP]) begin
				stop_hit = 1'b1;
			end
		end

		// Divider and count; a full 16-bit count simply wraps
		wrap = st.dcount == st.dlimit;
		if (step && !stop_hit) begin // Stop freezes both on the match value
			if (wrap) begin
				nx.dcount = '0;
				nx.tcount = rst_hit ? 16'h0000 : 16'(st.tcount + 16'h0001);
			end else begin
				nx.dcount = 16'(st.dcount + 16'h0001);
			end
		end

		// Match actions: flag and stop
		for (int i = 0; i < 4; i++) begin
			if (mev[i] && st.mact[i*`PCT_MACT_W + `PCT_MACT_IRQ]) begin
				setv[i] = 1'b1;
			end
			if (mev[i] && st.mact[i*`PCT_MACT_W + `PCT_MACT_STOP]) begin
				nx.runc[`PCT_RUN_EN] = 1'b0;
			end
		end

		// External match state on the two pinned channels
		for (int i = 0; i < 2; i++) begin
			act = pct_pkg::pct_em_t'(st.ext[`PCT_EXT_ACT + i*`PCT_EXT_ACT_W +: `PCT_EXT_ACT_W]);
			if (mev[i]) begin
				case (act)
					pct_pkg::PCT_EM_LOW:    nx.ext[i] = 1'b0;
					pct_pkg::PCT_EM_HIGH:   nx.ext[i] = 1'b1;
					pct_pkg::PCT_EM_TOGGLE: nx.ext[i] = !st.ext[i];
					default:                nx.ext[i] = st.ext[i];
				endcase
			end
		end

		// Captures load the current count
		for (int c = 0; c < 2; c++) begin
			cev[c] = pct_edge(st.cap_prev[c], capture_inputs_i[c],
				st.cedge[c*`PCT_CEDGE_W + `PCT_CEDGE_RISE],
				st.cedge[c*`PCT_CEDGE_W + `PCT_CEDGE_FALL]);
			if (cev[c]) begin
				nx.capv[c] = st.tcount;
			end
		end
		if (cev[0] && st.cedge[`PCT_CEDGE_IRQ]) begin
			setv[`PCT_FLAG_CAP0] = 1'b1;
		end
		if (cev[1] && st.cedge[`PCT_CEDGE_W + `PCT_CEDGE_IRQ]) begin
			setv[`PCT_FLAG_CAP1] = 1'b1;
		end
		nx.cap_prev = capture_inputs_i;

		// Clear on a chosen capture edge, for pulse-width measurement
		clr_ch = st.csrc[`PCT_CSRC_CLRCH];
		clr_cap = st.csrc[`PCT_CSRC_CLREN] && pct_edge(st.cap_prev[clr_ch],
			capture_inputs_i[clr_ch], !st.csrc[`PCT_CSRC_CLRFAL], st.csrc[`PCT_CSRC_CLRFAL]);
		if (clr_cap) begin
			nx.tcount = '0;
			nx.dcount = '0;
		end

		// Register writes, taken at the edge where waitrequest is low
		if (take_wr) begin
			case (avs_address_i)
				`PCT_OFS_FLAGS: clrv = wdz[6:0];
				`PCT_OFS_RUN:   nx.runc = wdm[1:0];
				`PCT_OFS_COUNT: nx.tcount = wdm[15:0];
				`PCT_OFS_LIMIT: nx.dlimit = wdm[15:0];
				`PCT_OFS_DIV:   nx.dcount = wdm[15:0];
				`PCT_OFS_MACT:  nx.mact = wdm[11:0];
				`PCT_OFS_CMP0:  nx.cmp[0] = wdm[15:0];
				`PCT_OFS_CMP1:  nx.cmp[1] = wdm[15:0];
				`PCT_OFS_CMP2:  nx.cmp[2] = wdm[15:0];
				`PCT_OFS_CMP3:  nx.cmp[3] = wdm[15:0];
				`PCT_OFS_CEDGE: nx.cedge = wdm[5:0];
				`PCT_OFS_EXT:   nx.ext = wdm[5:0];
				`PCT_OFS_CSRC:  nx.csrc = wdm[5:0];
				`PCT_OFS_PWM:   nx.pwm = wdm[1:0];
				default:        nx.pwm = st.pwm; // Unmapped or read-only: ignored
			endcase
		end
		// Only writing a one clears; flags without a bit here stay zero
		clrv[`PCT_FLAG_SPARE] = 1'b1;
		setv[`PCT_FLAG_SPARE] = 1'b0;

		// Flags: a new event beats a clear in the same cycle
		nx.iflags = (st.iflags & ~clrv) | setv;

		// Counter reset holds count and divider at zero while set
		if (nx.runc[`PCT_RUN_RST]) begin
			nx.tcount = '0;
			nx.dcount = '0;
		end

		// Pin drive: PWM is low below the compare value, high from it on
		for (int i = 0; i < 2; i++) begin
			nx.mout[i] = st.pwm[i] ? (nx.tcount >= st.cmp[i]) : nx.ext[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; all software-visible fields clear on reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st      <= `PCT_RST_ZERO;
			st.busy <= `PCT_RST_BUSY;
		end else begin
			st <= nx;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign avs_readdata_o    = st.rdata;
	assign avs_waitrequest_o = st.busy;
	assign match_outputs_o   = st.mout;

endmodule // pct_timer
`default_nettype wire
